// ==== src/fdc_regs.svh ====
// Purpose: constants of the fieldbus drive command block
// Assumes: included by its bare name
// Notes: telegram codes are decimal figures written in hex
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH

`define FDC_ADDR_DEFAULT 7'h7e
`define FDC_ADDR_MIN 7'h01
`define FDC_ADDR_MAX 7'h7d
`define FDC_SW_ALL_OFF 7'h00
`define FDC_SW_ALL_ON 7'h7f
`define FDC_SYNC_SETTLE 2'h2

`define FDC_TG_STD1 10'h001
`define FDC_TG_STD20 10'h014
`define FDC_TG_350 10'h15e
`define FDC_TG_352 10'h160
`define FDC_TG_353 10'h161
`define FDC_TG_354 10'h162
`define FDC_TG_FREE 10'h3e7
`define FDC_TG_DEFAULT 10'h001

`define FDC_CMD_WORD_IDX 3'h0
`define FDC_BIT_ON 0
`define FDC_BIT_NO_COAST 1
`define FDC_BIT_NO_QUICK 2
`define FDC_BIT_ENABLE_OP 3
`define FDC_BIT_RFG_KEEP 4
`define FDC_BIT_RFG_RUN 5
`define FDC_BIT_SETPOINT 6
`define FDC_BIT_ACK 7
`define FDC_BIT_BUS_CTRL 10
`define FDC_BIT_REVERSE 11
`define FDC_BIT_MOP_UP 13
`define FDC_BIT_MOP_DOWN 14
`define FDC_BIT_CDS0 15

`endif

// ==== src/fdc_pkg.sv ====
// Purpose: types of the fieldbus drive command block
// Assumes: nothing
// Notes: none
package fdc_pkg;
    typedef enum logic [1:0] {FDC_ST_LOCKOUT, FDC_ST_READY_START, FDC_ST_READY, FDC_ST_RUN} fdc_state_t;
    typedef enum logic [1:0] {FDC_RAMP_UP, FDC_RAMP_DOWN, FDC_RAMP_QUICK} fdc_ramp_t;

    typedef struct packed {
        logic [2:0] rx_words;
        logic [2:0] tx_words;
        logic [2:0] param_channel_words;
        logic free_map;
    } fdc_layout_t;

    typedef struct packed {
        logic ramp_stop_cmd;
        logic coast_stop_cmd;
        logic quick_stop_cmd;
        logic pulse_enable;
        logic rfg_zero;
        logic rfg_freeze;
        logic setpoint_enable;
        fdc_ramp_t ramp_sel;
        logic reverse;
        logic mop_up;
        logic mop_down;
        logic cds_bit0;
    } fdc_cmd_t;
endpackage

// ==== src/fdc_drive_control.sv ====
// Purpose: station address, telegram layout and command word decode of a drive
// Assumes: one 25 MHz clock, synchronous active-low reset, switches are async pins
// Notes: command word arrives as received process word 0
// Behaviour
// RULE1: a valid switch address wins and blocks changes to the stored address
// RULE2: stored address writes only with switches all off or all on
// RULE3: stored bus address resets to 126
// RULE4: a station address is valid only within 1 to 125
// RULE5: new address takes effect only after a full power restart
// RULE6: code 1 gives 2/2 words and is default; code 20 gives 2/6
// RULE7: code 350 gives 4/4 words; code 352 gives 6/6 without parameter channel
// RULE8: codes 353 and 354 carry 2/2 and 6/6 plus 4/4 parameter words
// RULE9: predefined telegrams map word by word; 999 is freely interconnected
// RULE10: bit 0 low ramps down and off; rising edge readies, runs with bit 3
// RULE11: bit 1 low coasts the motor; high permits switch-on
// RULE12: bit 2 low quick stops on its own ramp; high permits switch-on
// RULE13: bit 3 low cancels pulses; high allows pulse enable
// RULE14: bit 4 low forces ramp generator output to zero
// RULE15: bit 5 low freezes ramp generator output; high tracks setpoint
// RULE16: bit 6 low brakes on normal ramp; high accelerates on ramp-up
// RULE17: bit 7 rising edge acknowledges faults; on still high gives closing lockout
// RULE18: bit 10 low ignores fieldbus process data; high accepts it
// RULE19: outside telegram 20 bit 11 reverses the setpoint, active at 0
// RULE20: outside telegram 20 bits 13 and 14 raise and lower the potentiometer
// RULE21: in telegram 20 bit 15 is command data set bit 0; 8, 9, 12 ignored
// RULE22: entering telegram 20 keeps previous meaning of bits 11, 13, 14
// RULE23: command word is the first received process word of each telegram
`timescale 1ns/100ps
`include "fdc_regs.svh"

module fdc_drive_control #(
    parameter int ADDR_W = 7,
    parameter int TG_W = 10
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [ADDR_W-1:0] addr_switch_in,
    input wire logic addr_param_wr_in,
    input wire logic [ADDR_W-1:0] addr_param_data_in,
    input wire logic telegram_wr_in,
    input wire logic [TG_W-1:0] telegram_data_in,
    input wire logic rx_word_valid_in,
    input wire logic [2:0] rx_word_idx_in,
    input wire logic [15:0] rx_word_in,
    input wire logic fault_in,
    output logic [ADDR_W-1:0] stored_bus_address_out,
    output logic [ADDR_W-1:0] station_address_out,
    output logic station_address_valid_out,
    output logic addr_param_reject_out,
    output logic [TG_W-1:0] telegram_select_out,
    output fdc_pkg::fdc_layout_t layout_out,
    output logic telegram_reject_out,
    output logic bus_control_out,
    output fdc_pkg::fdc_cmd_t drive_cmd_out,
    output logic fault_active_out,
    output logic fault_ack_out,
    output logic closing_lockout_out,
    output logic ready_to_start_out,
    output logic ready_out,
    output logic operation_enabled_out
);
    import fdc_pkg::*;

    generate
        if (ADDR_W != 7 || TG_W != 10) begin : g_bad_width
            $error("fdc_drive_control supports only ADDR_W 7 and TG_W 10");
        end
    endgenerate

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a >= `FDC_ADDR_MIN) && (a <= `FDC_ADDR_MAX); // RULE4
    endfunction

    function automatic logic tg_layout(input logic [TG_W-1:0] code, output fdc_layout_t lay);
        lay = '0;
        tg_layout = 1'b1;
        case (code)
            `FDC_TG_STD1: lay = '{3'h2, 3'h2, 3'h0, 1'b0}; // RULE6
            `FDC_TG_STD20: lay = '{3'h2, 3'h6, 3'h0, 1'b0}; // RULE6
            `FDC_TG_350: lay = '{3'h4, 3'h4, 3'h0, 1'b0}; // RULE7
            `FDC_TG_352: lay = '{3'h6, 3'h6, 3'h0, 1'b0}; // RULE7
            `FDC_TG_353: lay = '{3'h2, 3'h2, 3'h4, 1'b0}; // RULE8
            `FDC_TG_354: lay = '{3'h6, 3'h6, 3'h4, 1'b0}; // RULE8
            `FDC_TG_FREE: lay = '{3'h6, 3'h6, 3'h0, 1'b1}; // RULE9
            default: tg_layout = 1'b0;
        endcase
    endfunction

    // address switch synchroniser and start-up capture
    logic [ADDR_W-1:0] sw_meta_r, sw_sync_r;
    logic [1:0] settle_r, settle_nxt;
    logic started_r, started_nxt;
    logic [ADDR_W-1:0] stored_r, stored_nxt, station_r, station_nxt;
    logic station_valid_r, station_valid_nxt, addr_rej_r, addr_rej_nxt;
    logic sw_valid, sw_writable;

    always_comb begin
        sw_valid = addr_ok(sw_sync_r);
        sw_writable = (sw_sync_r == `FDC_SW_ALL_OFF) || (sw_sync_r == `FDC_SW_ALL_ON); // RULE2
        settle_nxt = settle_r;
        started_nxt = started_r;
        stored_nxt = stored_r;
        station_nxt = station_r;
        station_valid_nxt = station_valid_r;
        addr_rej_nxt = 1'b0;
        if (settle_r != `FDC_SYNC_SETTLE) begin
            settle_nxt = settle_r + 2'h1;
        end else if (!started_r) begin
            // address adopted once per restart only
            started_nxt = 1'b1; // RULE5
            station_nxt = sw_valid ? sw_sync_r : stored_r; // RULE1
            station_valid_nxt = sw_valid || addr_ok(stored_r); // RULE4
        end
        if (addr_param_wr_in) begin
            if (sw_writable && !sw_valid) begin // RULE1 RULE2
                stored_nxt = addr_param_data_in;
            end else begin
                addr_rej_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        sw_meta_r <= addr_switch_in;
        sw_sync_r <= sw_meta_r;
        if (!resetn_in) begin
            settle_r <= 2'h0;
            started_r <= 1'b0;
            stored_r <= `FDC_ADDR_DEFAULT; // RULE3
            station_r <= '0;
            station_valid_r <= 1'b0;
            addr_rej_r <= 1'b0;
        end else begin
            settle_r <= settle_nxt;
            started_r <= started_nxt;
            stored_r <= stored_nxt;
            station_r <= station_nxt;
            station_valid_r <= station_valid_nxt;
            addr_rej_r <= addr_rej_nxt;
        end
    end

    // telegram selection
    logic [TG_W-1:0] tg_r, tg_nxt;
    fdc_layout_t lay_r, lay_nxt, lay_new;
    logic tg_rej_r, tg_rej_nxt, keep_ext_r, keep_ext_nxt, tg_known;

    always_comb begin
        tg_known = tg_layout(telegram_data_in, lay_new);
        tg_nxt = tg_r;
        lay_nxt = lay_r;
        tg_rej_nxt = 1'b0;
        keep_ext_nxt = keep_ext_r;
        if (telegram_wr_in) begin
            if (tg_known) begin
                tg_nxt = telegram_data_in;
                lay_nxt = lay_new;
                if (telegram_data_in == `FDC_TG_STD20 && tg_r != `FDC_TG_STD20) begin
                    keep_ext_nxt = 1'b1; // RULE22
                end else if (telegram_data_in != `FDC_TG_STD20) begin
                    keep_ext_nxt = 1'b0;
                end
            end else begin
                tg_rej_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            tg_r <= `FDC_TG_DEFAULT; // RULE6
            lay_r <= '{3'h2, 3'h2, 3'h0, 1'b0};
            tg_rej_r <= 1'b0;
            keep_ext_r <= 1'b0;
        end else begin
            tg_r <= tg_nxt;
            lay_r <= lay_nxt;
            tg_rej_r <= tg_rej_nxt;
            keep_ext_r <= keep_ext_nxt;
        end
    end

    // command word capture, decode and drive sequence
    logic [15:0] word_r, word_nxt;
    logic bus_ctrl_r, bus_ctrl_nxt, fault_r, fault_nxt, ack_r, ack_nxt;
    fdc_state_t state_r, state_nxt;
    fdc_cmd_t cmd_r, cmd_nxt;
    logic on_b, coast_ok, quick_ok, ext_ok, tg20, ack_edge, on_edge;

    always_comb begin
        word_nxt = word_r;
        bus_ctrl_nxt = bus_ctrl_r;
        if (rx_word_valid_in && rx_word_idx_in == `FDC_CMD_WORD_IDX) begin // RULE23
            bus_ctrl_nxt = rx_word_in[`FDC_BIT_BUS_CTRL];
            if (rx_word_in[`FDC_BIT_BUS_CTRL]) begin
                word_nxt = rx_word_in; // RULE18
            end
        end
        on_b = word_r[`FDC_BIT_ON];
        coast_ok = word_r[`FDC_BIT_NO_COAST];
        quick_ok = word_r[`FDC_BIT_NO_QUICK];
        tg20 = (tg_r == `FDC_TG_STD20);
        ext_ok = !tg20 || keep_ext_r; // RULE19 RULE20 RULE22
        on_edge = on_b && !word_nxt[`FDC_BIT_ON] ? 1'b0 : (!on_b && word_nxt[`FDC_BIT_ON]);
        ack_edge = !word_r[`FDC_BIT_ACK] && word_nxt[`FDC_BIT_ACK]; // RULE17
        ack_nxt = ack_edge;
        // a new fault beats a simultaneous acknowledge
        fault_nxt = fault_in || (fault_r && !ack_edge); // RULE17
        state_nxt = state_r;
        case (state_r)
            FDC_ST_LOCKOUT: begin
                if (!on_b && coast_ok && quick_ok && !fault_r) begin // RULE17
                    state_nxt = FDC_ST_READY_START;
                end
            end
            FDC_ST_READY_START: begin
                if (!coast_ok || !quick_ok) begin
                    state_nxt = FDC_ST_LOCKOUT; // RULE11 RULE12
                end else if (on_edge) begin
                    state_nxt = FDC_ST_READY; // RULE10
                end
            end
            FDC_ST_READY: begin
                if (!coast_ok || !quick_ok) begin
                    state_nxt = FDC_ST_LOCKOUT;
                end else if (!on_b) begin
                    state_nxt = FDC_ST_READY_START; // RULE10
                end else if (word_r[`FDC_BIT_ENABLE_OP]) begin
                    state_nxt = FDC_ST_RUN; // RULE10 RULE13
                end
            end
            FDC_ST_RUN: begin
                if (!coast_ok || !quick_ok) begin
                    state_nxt = FDC_ST_LOCKOUT; // RULE11 RULE12
                end else if (!on_b) begin
                    state_nxt = FDC_ST_READY_START; // RULE10
                end else if (!word_r[`FDC_BIT_ENABLE_OP]) begin
                    state_nxt = FDC_ST_READY; // RULE13
                end
            end
            default: state_nxt = FDC_ST_LOCKOUT;
        endcase
        if (fault_r) begin
            state_nxt = FDC_ST_LOCKOUT;
        end
        cmd_nxt.ramp_stop_cmd = !on_b; // RULE10
        cmd_nxt.coast_stop_cmd = !coast_ok; // RULE11
        cmd_nxt.quick_stop_cmd = !quick_ok; // RULE12
        cmd_nxt.pulse_enable = (state_nxt == FDC_ST_RUN); // RULE13
        cmd_nxt.rfg_zero = !word_r[`FDC_BIT_RFG_KEEP]; // RULE14
        cmd_nxt.rfg_freeze = !word_r[`FDC_BIT_RFG_RUN]; // RULE15
        cmd_nxt.setpoint_enable = word_r[`FDC_BIT_SETPOINT]; // RULE16
        if (!quick_ok) begin
            cmd_nxt.ramp_sel = FDC_RAMP_QUICK; // RULE12
        end else if (!on_b || !word_r[`FDC_BIT_SETPOINT]) begin
            cmd_nxt.ramp_sel = FDC_RAMP_DOWN; // RULE16
        end else begin
            cmd_nxt.ramp_sel = FDC_RAMP_UP;
        end
        cmd_nxt.reverse = ext_ok && !word_r[`FDC_BIT_REVERSE]; // RULE19
        cmd_nxt.mop_up = ext_ok && word_r[`FDC_BIT_MOP_UP]; // RULE20
        cmd_nxt.mop_down = ext_ok && word_r[`FDC_BIT_MOP_DOWN]; // RULE20
        cmd_nxt.cds_bit0 = tg20 && word_r[`FDC_BIT_CDS0]; // RULE21
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            word_r <= 16'h0000;
            bus_ctrl_r <= 1'b0;
            fault_r <= 1'b0;
            ack_r <= 1'b0;
            state_r <= FDC_ST_LOCKOUT;
            cmd_r <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, FDC_RAMP_QUICK, 1'b0, 1'b0, 1'b0, 1'b0};
        end else begin
            word_r <= word_nxt;
            bus_ctrl_r <= bus_ctrl_nxt;
            fault_r <= fault_nxt;
            ack_r <= ack_nxt;
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
        end
    end

    assign stored_bus_address_out = stored_r;
    assign station_address_out = station_r;
    assign station_address_valid_out = station_valid_r;
    assign addr_param_reject_out = addr_rej_r;
    assign telegram_select_out = tg_r;
    assign layout_out = lay_r;
    assign telegram_reject_out = tg_rej_r;
    assign bus_control_out = bus_ctrl_r;
    assign drive_cmd_out = cmd_r;
    assign fault_active_out = fault_r;
    assign fault_ack_out = ack_r;
    assign closing_lockout_out = (state_r == FDC_ST_LOCKOUT);
    assign ready_to_start_out = (state_r == FDC_ST_READY_START);
    assign ready_out = (state_r == FDC_ST_READY) || (state_r == FDC_ST_RUN);
    assign operation_enabled_out = (state_r == FDC_ST_RUN);
endmodule

// ==== dv/fdc_plc_model.sv ====
// Purpose: bus master that places the command word
// Assumes: one word per send pulse
// Notes: idle word line toggles
`timescale 1ns/100ps
module fdc_plc_model (
    input wire logic ref_clk_in,
    input wire logic send_in,
    input wire logic [15:0] word_in,
    output logic valid_out,
    output logic [2:0] idx_out,
    output logic [15:0] word_out
);
    logic valid_r = 1'b0;
    logic [2:0] idx_r = 3'h5;
    logic [15:0] word_r = 16'h0000;
    assign valid_out = valid_r;
    assign idx_out = idx_r;
    assign word_out = word_r;
    // between sends the last word alternates with its complement on the line
    always @(posedge ref_clk_in) begin
        valid_r <= send_in;
        idx_r <= send_in ? 3'h0 : 3'h5;
        word_r <= send_in ? word_in : ~word_r;
    end
endmodule

// ==== dv/fdc_drive_control_properties.sv ====
// Purpose: port checks of the drive command block
// Assumes: bound to fdc_drive_control
// Notes: switch sync is two flops deep
`timescale 1ns/100ps
module fdc_drive_checker (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [6:0] addr_switch_in,
    input wire logic addr_param_wr_in,
    input wire logic [6:0] addr_param_data_in,
    input wire logic telegram_wr_in,
    input wire logic [9:0] telegram_data_in,
    input wire logic rx_word_valid_in,
    input wire logic [2:0] rx_word_idx_in,
    input wire logic [15:0] rx_word_in,
    input wire logic fault_in,
    input wire logic [6:0] stored_bus_address_out,
    input wire logic addr_param_reject_out,
    input wire logic [9:0] telegram_select_out,
    input wire fdc_pkg::fdc_layout_t layout_out,
    input wire logic telegram_reject_out,
    input wire logic bus_control_out,
    input wire fdc_pkg::fdc_cmd_t drive_cmd_out,
    input wire logic fault_active_out,
    input wire logic fault_ack_out,
    input wire logic operation_enabled_out
);
    import fdc_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    function automatic logic [9:0] lay(input logic [9:0] c);
        case (c)
            10'h001: lay = 10'h120;
            10'h014: lay = 10'h160;
            10'h15e: lay = 10'h240;
            10'h160: lay = 10'h360;
            10'h161: lay = 10'h128;
            10'h162: lay = 10'h368;
            10'h3e7: lay = 10'h361;
            default: lay = 10'h000;
        endcase
    endfunction
    sequence sw_held;
        $stable(addr_switch_in) && addr_switch_in == $past(addr_switch_in, 2) && $past(resetn_in, 3);
    endsequence
    sequence word_in0;
        rx_word_valid_in && rx_word_idx_in == 3'h0;
    endsequence
    a_addr_refused: assert property (sw_held ##0 addr_param_wr_in && !(addr_switch_in inside {7'h00, 7'h7f})
        |=> addr_param_reject_out && $stable(stored_bus_address_out)) else $error("address write not refused");
    a_addr_taken: assert property (sw_held ##0 addr_param_wr_in && addr_switch_in inside {7'h00, 7'h7f}
        |=> stored_bus_address_out == $past(addr_param_data_in)) else $error("address write lost");
    a_addr_default: assert property (disable iff (1'b0) !resetn_in |=> stored_bus_address_out == 7'h7e)
        else $error("stored address reset wrong");
    a_tg_layout: assert property (telegram_wr_in && lay(telegram_data_in) != 10'h000
        |=> telegram_select_out == $past(telegram_data_in) && layout_out == lay($past(telegram_data_in)))
        else $error("telegram layout wrong");
    a_tg_refused: assert property (telegram_wr_in && lay(telegram_data_in) == 10'h000
        |=> telegram_reject_out && $stable(layout_out)) else $error("unknown telegram taken");
    a_bus_follow: assert property (word_in0 |=> bus_control_out == $past(rx_word_in[10]))
        else $error("bus control bit wrong");
    a_word_ignored: assert property (word_in0 ##0 !rx_word_in[10] |=> ##1 $stable(drive_cmd_out.reverse))
        else $error("ignored word changed command");
    a_dir_mop: assert property (word_in0 ##0 rx_word_in[10] |=> ##1 drive_cmd_out.reverse == !$past(rx_word_in[11], 2)
        && drive_cmd_out.mop_up == $past(rx_word_in[13], 2) && drive_cmd_out.mop_down == $past(rx_word_in[14], 2))
        else $error("direction or potentiometer wrong");
    a_stop_bits: assert property (word_in0 ##0 rx_word_in[10] |=> ##1 drive_cmd_out.coast_stop_cmd == !$past(rx_word_in[1], 2)
        && drive_cmd_out.quick_stop_cmd == !$past(rx_word_in[2], 2) && drive_cmd_out.rfg_zero == !$past(rx_word_in[4], 2))
        else $error("stop command wrong");
    a_fault_sticky: assert property (fault_in |=> fault_active_out) else $error("fault not held");
    a_pulse_run: assert property (drive_cmd_out.pulse_enable == operation_enabled_out)
        else $error("pulse enable apart from run");
    // an accepted acknowledge leaves the fault set only by a fault in the same cycle
    a_fault_ack_clears: assert property (fault_ack_out |-> fault_active_out == $past(fault_in))
        else $error("acknowledge left fault set");
endmodule
bind fdc_drive_control fdc_drive_checker chk_u (.*);

// ==== dv/fdc_drive_control_tb.sv ====
// Purpose: self-checking bench of the drive command block
// Assumes: partner model feeds the received word port
// Notes: fixed latencies as handed over
`timescale 1ns/100ps
module fdc_drive_control_tb;
    import fdc_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, awr = 1'b0, twr = 1'b0, send = 1'b0, fault = 1'b0;
    logic [6:0] sw = 7'h00, adata = 7'h00, stored, station;
    logic [9:0] tdata = 10'h001, tsel;
    logic [15:0] sword = 16'h0000, rxw, last;
    logic [2:0] rxi;
    logic rxv, stv, arej, trej, busc, fact, lockout, opena, rts, rdy;
    fdc_layout_t layo;
    fdc_cmd_t dcmd;
    int miscompares = 0, comparisons = 0;
    localparam logic [9:0] CODES [7] = '{10'h001, 10'h014, 10'h15e, 10'h160, 10'h161, 10'h162, 10'h3e7};
    localparam logic [9:0] LAYS [7] = '{10'h120, 10'h160, 10'h240, 10'h360, 10'h128, 10'h368, 10'h361};
    localparam logic [15:0] WORDS [15] = '{16'h0406, 16'h047f, 16'h2c7f, 16'h4b7f, 16'h4c7f, 16'h4c7d, 16'h0406,
        16'h047f, 16'h047b, 16'h0406, 16'h047f, 16'h0477, 16'h046f, 16'h045f, 16'h043f};
    localparam logic RUNS [15] = '{0, 1, 1, 1, 1, 0, 0, 1, 0, 0, 1, 0, 1, 1, 1};
    // expected {closing lockout, ready to start, ready} after each word
    localparam logic [2:0] PHASES [15] = '{3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h2, 3'h1, 3'h4, 3'h2, 3'h1,
        3'h1, 3'h1, 3'h1, 3'h1};
    always #20 clk = ~clk;
    fdc_plc_model plc_u (.ref_clk_in(clk), .send_in(send), .word_in(sword), .valid_out(rxv), .idx_out(rxi),
        .word_out(rxw));
    fdc_drive_control dut_u (.ref_clk_in(clk), .resetn_in(resetn), .addr_switch_in(sw), .addr_param_wr_in(awr),
        .addr_param_data_in(adata), .telegram_wr_in(twr), .telegram_data_in(tdata), .rx_word_valid_in(rxv),
        .rx_word_idx_in(rxi), .rx_word_in(rxw), .fault_in(fault), .stored_bus_address_out(stored),
        .station_address_out(station), .station_address_valid_out(stv), .addr_param_reject_out(arej),
        .telegram_select_out(tsel), .layout_out(layo), .telegram_reject_out(trej), .bus_control_out(busc),
        .drive_cmd_out(dcmd), .fault_active_out(fact), .fault_ack_out(), .closing_lockout_out(lockout),
        .ready_to_start_out(rts), .ready_out(rdy), .operation_enabled_out(opena));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // full restart, the only point where a new address is adopted
    task automatic restart(input logic [6:0] s);
        @(posedge clk);
        sw <= s;
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic set_sw(input logic [6:0] s);
        @(posedge clk);
        sw <= s;
        repeat (3) @(posedge clk);
    endtask
    task automatic addr_wr(input logic [6:0] d);
        @(posedge clk);
        awr <= 1'b1;
        adata <= d;
        @(posedge clk);
        awr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic tg_wr(input logic [9:0] c);
        @(posedge clk);
        twr <= 1'b1;
        tdata <= c;
        @(posedge clk);
        twr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic cmd(input logic [15:0] w);
        @(posedge clk);
        send <= 1'b1;
        sword <= w;
        @(posedge clk);
        send <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_run;
        for (int n = 0; n < 8 && opena !== 1'b1; n++) @(negedge clk);
        if (opena !== 1'b1) begin
            miscompares++;
            complete_run();
        end
    endtask
    function automatic logic [12:0] exp_cmd(input logic [15:0] w, input logic run);
        exp_cmd = {!w[0], !w[1], !w[2], run, !w[4], !w[5], w[6], 2'b00, !w[11], w[13], w[14], 1'b0};
    endfunction
    initial begin
        restart(7'h00);
        check(stored, 7'h7e);
        check(stv, 1'b0);
        check(layo, 10'h120);
        check(lockout, 1'b1);
        addr_wr(7'h05);
        check(stored, 7'h05);
        check(station, 7'h7e);
        set_sw(7'h7f);
        addr_wr(7'h09);
        check(stored, 7'h09);
        set_sw(7'h7e);
        addr_wr(7'h11);
        check(arej, 1'b1);
        set_sw(7'h40);
        addr_wr(7'h12);
        check(arej, 1'b1);
        check(stored, 7'h09);
        restart(7'h40);
        check(station, 7'h40);
        for (int i = 0; i < 3; i++) begin
            restart(i == 0 ? 7'h01 : (i == 1 ? 7'h7d : 7'h7e));
            check(stv, i < 2);
        end
        for (int i = 0; i < 7; i++) begin
            tg_wr(CODES[i]);
            check(tsel, CODES[i]);
            check(layo, LAYS[i]);
        end
        tg_wr(10'h002);
        check(trej, 1'b1);
        check(tsel, 10'h3e7);
        tg_wr(10'h001);
        last = 16'h0000;
        for (int i = 0; i < 15; i++) begin
            cmd(WORDS[i]);
            if (WORDS[i][10]) last = WORDS[i];
            if (RUNS[i]) wait_run();
            check(dcmd & 13'h1fcf, exp_cmd(last, RUNS[i]));
            check(opena, RUNS[i]);
            check(busc, WORDS[i][10]);
            check({lockout, rts, rdy}, PHASES[i]);
            check(dcmd.ramp_sel, !last[2] ? 2'h2 : ((!last[0] || !last[6]) ? 2'h1 : 2'h0));
        end
        @(posedge clk);
        fault <= 1'b1;
        @(posedge clk);
        fault <= 1'b0;
        @(negedge clk);
        check(fact, 1'b1);
        // the state falls to lockout one cycle after the sticky fault is set
        @(negedge clk);
        check(lockout, 1'b1);
        // acknowledge while on is still asserted stays in closing lockout
        cmd(16'h0487);
        check(fact, 1'b0);
        check(lockout, 1'b1);
        cmd(16'h0486);
        check(fact, 1'b0);
        check(rts, 1'b1);
        tg_wr(10'h014);
        cmd(16'h9706);
        check(dcmd & 13'h1fcf, exp_cmd(16'h0406, 1'b0) | 13'h0001);
        check(dcmd.reverse, 1'b1);
        complete_run();
    end
endmodule
